// file: loop_filter_model.sv
// Loop filter stand-in feeding duty and period to the edge generator
`timescale 1ns/1ps

module loop_filter_model (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst_n,
  input  wire logic [15:0]         i_duty,
  output pwm_edge_pkg::filter_in_t o_filter
);
  // Registered like a real filter output
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_filter <= '0;
    else
    begin
      o_filter.duty   <= i_duty;
      o_filter.period <= {i_duty[14:0], 1'b0};
    end
  end
endmodule

// file: multimode_pwm_edge_generator.sv
// Multimode PWM edge generator with Avalon-MM register slave
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps

// What this block does
// - A period counter runs from zero up to the period limit, clears and repeats.
// - Each output changes state when the counter equals its computed target.
// - Normal mode: A rises at event 1 and falls at event 1 plus duty plus adjust A.
// - Normal mode: B rises at A's fall point plus event 3 minus event 2.
// - Normal mode: B falls at event 4 plus the dead-time compensation.
// - The adaptive trigger sits at event 1 plus duty or half duty, plus its offset.
// - The phase trigger comes from the phase register or from the duty sampled at the period boundary.
// - Sample triggers and blanking windows come straight from their registers.
// - Normal mode ignores cycle adjust B.
// - Multi mode: A rises at event 1, falls at event 1 plus duty, adjust A and dead-time.
// - Multi mode: B rises at event 3, falls at event 3 plus duty, adjust B and dead-time.
// - Multi mode uses neither event 2 nor event 4.
// - Multi mode: B may wrap past period end at full width; A may not.
// - Resonant mode: A rises at event 1 and falls at duty minus event 1 plus dead-time.
// - Resonant mode: B rises at duty plus event 1, falls at period minus event 1 plus dead-time.
module multimode_pwm_edge_generator #(
  parameter int W = pwm_edge_pkg::CNT_W
) (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rst_n,
  input  wire pwm_edge_pkg::filter_in_t i_filter,
  input  wire logic [5:0]             i_avs_address,
  input  wire logic                   i_avs_read,
  input  wire logic                   i_avs_write,
  input  wire logic [31:0]            i_avs_writedata,
  input  wire logic [3:0]             i_avs_byteenable,
  output logic [31:0]                 o_avs_readdata,
  output logic                        o_avs_waitrequest,
  output pwm_edge_pkg::pwm_out_t      o_pwm
);

  // Register file
  logic [31:0]  ctrl;
  logic [W-1:0] limit;
  logic [W-1:0] ev1;
  logic [W-1:0] ev2;
  logic [W-1:0] ev3;
  logic [W-1:0] ev4;
  logic [W-1:0] adj_a;
  logic [W-1:0] adj_b;
  logic [W-1:0] dead_time_comp;
  logic [W-1:0] adapt;
  logic [W-1:0] phase;
  logic [31:0]  sample;
  logic [31:0]  blank_a;
  logic [31:0]  blank_b;
  logic         acked;
  logic [31:0]  rd_data;
  logic [W-1:0] count;
  logic [W-1:0] duty;
  logic [W-1:0] period;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction

  function automatic logic [W-1:0] low(input logic [31:0] v);
    return v[W-1:0];
  endfunction

  function automatic logic [31:0] wide(input logic [W-1:0] v);
    return {{(32-W){1'b0}}, v};
  endfunction

  // One wait state per access; answer on the second cycle of the request
  wire access = (i_avs_read || i_avs_write) && !acked;
  wire wr_go  = i_avs_write && acked;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !acked;

  wire [5:0] a = i_avs_address;
  wire [31:0] wd = i_avs_writedata;
  wire [3:0] be = i_avs_byteenable;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      acked <= 1'b0;
    else
      acked <= access;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl    <= 32'h0000_0000;
      limit   <= pwm_edge_pkg::LIMIT_INIT;
      ev1     <= '0;
      ev2     <= '0;
      ev3     <= '0;
      ev4     <= '0;
      adj_a   <= '0;
      adj_b   <= '0;
      dead_time_comp     <= '0;
      adapt   <= '0;
      phase   <= '0;
      sample  <= 32'h0000_0000;
      blank_a <= 32'h0000_0000;
      blank_b <= 32'h0000_0000;
    end
    else if (wr_go)
    begin
      if (a == pwm_edge_pkg::REG_CTRL)
        ctrl <= merge(ctrl, wd, be) & 32'h0000_001F;
      else if (a == pwm_edge_pkg::REG_LIMIT)
        limit <= low(merge(wide(limit), wd, be));
      else if (a == pwm_edge_pkg::REG_EVENT1)
        ev1 <= low(merge(wide(ev1), wd, be));
      else if (a == pwm_edge_pkg::REG_EVENT2)
        ev2 <= low(merge(wide(ev2), wd, be));
      else if (a == pwm_edge_pkg::REG_EVENT3)
        ev3 <= low(merge(wide(ev3), wd, be));
      else if (a == pwm_edge_pkg::REG_EVENT4)
        ev4 <= low(merge(wide(ev4), wd, be));
      else if (a == pwm_edge_pkg::REG_ADJ_A)
        adj_a <= low(merge(wide(adj_a), wd, be));
      else if (a == pwm_edge_pkg::REG_ADJ_B)
        adj_b <= low(merge(wide(adj_b), wd, be));
      else if (a == pwm_edge_pkg::REG_DTC)
        dead_time_comp <= low(merge(wide(dead_time_comp), wd, be));
      else if (a == pwm_edge_pkg::REG_ADAPT)
        adapt <= low(merge(wide(adapt), wd, be));
      else if (a == pwm_edge_pkg::REG_PHASE)
        phase <= low(merge(wide(phase), wd, be));
      else if (a == pwm_edge_pkg::REG_SAMPLE)
        sample <= merge(sample, wd, be);
      else if (a == pwm_edge_pkg::REG_BLANK_A)
        blank_a <= merge(blank_a, wd, be);
      else if (a == pwm_edge_pkg::REG_BLANK_B)
        blank_b <= merge(blank_b, wd, be);
    end
  end

  wire [31:0] status_word = {14'h0000, o_pwm.pwm_a, o_pwm.pwm_b, count};

  assign rd_data =
    (a == pwm_edge_pkg::REG_CTRL)    ? ctrl :
    (a == pwm_edge_pkg::REG_LIMIT)   ? wide(limit) :
    (a == pwm_edge_pkg::REG_EVENT1)  ? wide(ev1) :
    (a == pwm_edge_pkg::REG_EVENT2)  ? wide(ev2) :
    (a == pwm_edge_pkg::REG_EVENT3)  ? wide(ev3) :
    (a == pwm_edge_pkg::REG_EVENT4)  ? wide(ev4) :
    (a == pwm_edge_pkg::REG_ADJ_A)   ? wide(adj_a) :
    (a == pwm_edge_pkg::REG_ADJ_B)   ? wide(adj_b) :
    (a == pwm_edge_pkg::REG_DTC)     ? wide(dead_time_comp) :
    (a == pwm_edge_pkg::REG_ADAPT)   ? wide(adapt) :
    (a == pwm_edge_pkg::REG_PHASE)   ? wide(phase) :
    (a == pwm_edge_pkg::REG_SAMPLE)  ? sample :
    (a == pwm_edge_pkg::REG_BLANK_A) ? blank_a :
    (a == pwm_edge_pkg::REG_BLANK_B) ? blank_b :
    (a == pwm_edge_pkg::REG_STATUS)  ? status_word :
    pwm_edge_pkg::UNMAPPED_DATA;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_avs_readdata <= 32'h0000_0000;
    else if (i_avs_read && !acked)
      o_avs_readdata <= rd_data;
  end

  // Filter values are sampled at the period boundary to keep edges coherent
  wire run = ctrl[pwm_edge_pkg::CTRL_ENABLE];
  wire wrap = (count >= limit);

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count <= pwm_edge_pkg::CNT_RESET;
    else if (!run || wrap)
      count <= pwm_edge_pkg::CNT_RESET;
    else
      count <= count + 1'b1;
  end

  // Period value is expected at twice the duty in resonant mode
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      duty   <= '0;
      period <= '0;
    end
    else if (!run || wrap)
    begin
      duty   <= i_filter.duty;
      period <= i_filter.period;
    end
  end

  // Edge targets per mode
  pwm_edge_pkg::pwm_mode_t mode;
  assign mode = pwm_edge_pkg::pwm_mode_t'(ctrl[pwm_edge_pkg::CTRL_MODE_LSB +: 2]);

  wire [W-1:0] a_fall_norm = ev1 + duty + adj_a;
  wire [W-1:0] b_rise_norm = a_fall_norm + (ev3 - ev2);
  wire [W-1:0] b_fall_norm = ev4 + dead_time_comp;
  wire [W-1:0] a_fall_mult = ev1 + duty + adj_a + dead_time_comp;
  wire [W-1:0] b_fall_raw  = ev3 + duty + adj_b + dead_time_comp;
  // B wraps modulo the period length; A is clamped to the period end
  wire [W:0]   b_sum_ext   = {1'b0, ev3} + {1'b0, duty} + {1'b0, adj_b} + {1'b0, dead_time_comp};
  wire [W:0]   per_len     = {1'b0, limit} + 1'b1;
  wire [W:0]   b_wrapped   = (b_sum_ext >= per_len) ? b_sum_ext - per_len : b_sum_ext;
  wire [W-1:0] b_fall_mult = (b_sum_ext >= per_len) ? b_wrapped[W-1:0] : b_fall_raw;
  wire [W-1:0] a_fall_mcl  = (a_fall_mult > limit) ? limit : a_fall_mult;
  wire [W-1:0] a_fall_res  = duty - ev1 + dead_time_comp;
  wire [W-1:0] b_rise_res  = duty + ev1;
  wire [W-1:0] b_fall_res  = period - ev1 + dead_time_comp;

  wire [W-1:0] a_rise = ev1;
  wire [W-1:0] a_fall = (mode == pwm_edge_pkg::MODE_MULTI)    ? a_fall_mcl :
                        (mode == pwm_edge_pkg::MODE_RESONANT) ? a_fall_res : a_fall_norm;
  wire [W-1:0] b_rise = (mode == pwm_edge_pkg::MODE_MULTI)    ? ev3 :
                        (mode == pwm_edge_pkg::MODE_RESONANT) ? b_rise_res : b_rise_norm;
  wire [W-1:0] b_fall = (mode == pwm_edge_pkg::MODE_MULTI)    ? b_fall_mult :
                        (mode == pwm_edge_pkg::MODE_RESONANT) ? b_fall_res : b_fall_norm;

  wire [W-1:0] adapt_pt = ctrl[pwm_edge_pkg::CTRL_ADAPT_HALF] ?
                          ev1 + (duty >> 1) + adapt : ev1 + duty + adapt;
  wire [W-1:0] phase_pt = ctrl[pwm_edge_pkg::CTRL_PHASE_DUTY] ? duty : phase;

  logic lvl_a;
  logic lvl_b;
  logic lvl_ba;
  logic lvl_bb;

  pwm_edge_gate #(.W(W)) u_gate_a (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_run     (run),
    .i_count   (count),
    .i_rise    (a_rise),
    .i_fall    (a_fall),
    .o_level   (lvl_a)
  );

  pwm_edge_gate #(.W(W)) u_gate_b (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_run     (run),
    .i_count   (count),
    .i_rise    (b_rise),
    .i_fall    (b_fall),
    .o_level   (lvl_b)
  );

  pwm_edge_gate #(.W(W)) u_blank_a (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_run     (run),
    .i_count   (count),
    .i_rise    (blank_a[W-1:0]),
    .i_fall    (blank_a[16 +: W]),
    .o_level   (lvl_ba)
  );

  pwm_edge_gate #(.W(W)) u_blank_b (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_run     (run),
    .i_count   (count),
    .i_rise    (blank_b[W-1:0]),
    .i_fall    (blank_b[16 +: W]),
    .o_level   (lvl_bb)
  );

  // Trigger pulses, one cycle per match
  logic trig_adapt;
  logic trig_phase;
  logic trig_s1;
  logic trig_s2;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      trig_adapt <= 1'b0;
      trig_phase <= 1'b0;
      trig_s1    <= 1'b0;
      trig_s2    <= 1'b0;
    end
    else
    begin
      trig_adapt <= run && (count == adapt_pt);
      trig_phase <= run && (count == phase_pt);
      trig_s1    <= run && (count == sample[W-1:0]);
      trig_s2    <= run && (count == sample[16 +: W]);
    end
  end

  assign o_pwm.pwm_a      = lvl_a;
  assign o_pwm.pwm_b      = lvl_b;
  assign o_pwm.adapt_trig = trig_adapt;
  assign o_pwm.phase_trig = trig_phase;
  assign o_pwm.sample1    = trig_s1;
  assign o_pwm.sample2    = trig_s2;
  assign o_pwm.blank_a    = lvl_ba;
  assign o_pwm.blank_b    = lvl_bb;

  a_count_wrap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    run && count >= limit |=> count == '0)
    else $error("counter did not clear at period limit");

  a_count_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    run && $past(run) && count != '0 |-> count == $past(count) + 1'b1)
    else $error("counter did not step by one");

  a_a_rise: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    run && count == a_rise && count != a_fall |=> lvl_a)
    else $error("output A missed its rise");

  a_a_fall: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    run && count == a_fall |=> !lvl_a)
    else $error("output A missed its fall");

  a_b_fall: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    run && count == b_fall |=> !lvl_b)
    else $error("output B missed its fall");

  a_norm_adjb: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode == pwm_edge_pkg::MODE_NORMAL |->
      b_rise == ev1 + duty + adj_a + (ev3 - ev2) && b_fall == ev4 + dead_time_comp)
    else $error("normal mode B edge wrong");

  a_res_brise: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    mode == pwm_edge_pkg::MODE_RESONANT |-> b_rise == duty + ev1)
    else $error("resonant B rise wrong");

  a_adapt_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    run && !ctrl[pwm_edge_pkg::CTRL_ADAPT_HALF] && count == ev1 + duty + adapt |=> trig_adapt)
    else $error("adaptive trigger missed");

  a_phase_src: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    run && count == phase_pt |=> trig_phase)
    else $error("phase trigger missed");

  a_idle_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !run |=> !lvl_a && !lvl_b)
    else $error("outputs active while stopped");

endmodule

// file: multimode_pwm_edge_generator_bench.sv
// Self-checking bench for the multimode PWM edge generator
`timescale 1ns/1ps

module multimode_pwm_edge_generator_bench;
  logic                     i_clk_sys = 1'b0;
  logic                     i_rst_n;
  logic [5:0]               adr;
  logic                     rd;
  logic                     wr;
  logic [31:0]              wdat;
  logic [31:0]              rdat;
  logic                     wait_req;
  logic [15:0]              duty;
  pwm_edge_pkg::filter_in_t filt;
  pwm_edge_pkg::pwm_out_t   pwm;
  logic [7:0]               prev = 8'h00;
  logic [15:0]              p = 16'h0000;
  logic [15:0]              per_len;
  logic [15:0]              rise_at [8];
  logic [15:0]              fall_at [8];
  int                       n_errors = 0;
  int                       checks_done = 0;

  always #2.5 i_clk_sys = ~i_clk_sys;

  loop_filter_model filter (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_duty    (duty),
    .o_filter  (filt)
  );

  multimode_pwm_edge_generator DUT (
    .i_clk_sys         (i_clk_sys),
    .i_rst_n           (i_rst_n),
    .i_filter          (filt),
    .i_avs_address     (adr),
    .i_avs_read        (rd),
    .i_avs_write       (wr),
    .i_avs_writedata   (wdat),
    .i_avs_byteenable  (4'hF),
    .o_avs_readdata    (rdat),
    .o_avs_waitrequest (wait_req),
    .o_pwm             (pwm)
  );

  // Position in period, zero at the trigger-1 pulse placed on count 0
  always @(posedge i_clk_sys)
  begin
    if (pwm.sample1)
    begin
      per_len = p + 16'h0001;
      p = 16'h0000;
    end
    else
      p = p + 16'h0001;
    for (int b = 0; b < 8; b++)
    begin
      if (pwm[b] && !prev[b])
        rise_at[b] = p;
      if (!pwm[b] && prev[b])
        fall_at[b] = p;
    end
    prev = pwm;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge i_clk_sys);
    adr  <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= d;
    do @(posedge i_clk_sys); while (wait_req !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rreg(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask

  // Trigger pulses pass f as FFFF and must last one cycle
  task automatic ck(input int b, input logic [15:0] r, input logic [15:0] f);
    check({16'h0000, rise_at[b]}, {16'h0000, r});
    if (f === 16'hFFFF)
      check({16'h0000, fall_at[b]}, {16'h0000, r + 16'h0001});
    else
      check({16'h0000, fall_at[b]}, {16'h0000, f});
  endtask

  task automatic setup(input logic [15:0] e1, e2, e3, e4, aa, ab, dt, d,
                       input logic [31:0] ctl);
    duty <= d;
    wreg(pwm_edge_pkg::REG_EVENT1, {16'h0000, e1});
    wreg(pwm_edge_pkg::REG_EVENT2, {16'h0000, e2});
    wreg(pwm_edge_pkg::REG_EVENT3, {16'h0000, e3});
    wreg(pwm_edge_pkg::REG_EVENT4, {16'h0000, e4});
    wreg(pwm_edge_pkg::REG_ADJ_A, {16'h0000, aa});
    wreg(pwm_edge_pkg::REG_ADJ_B, {16'h0000, ab});
    wreg(pwm_edge_pkg::REG_DTC, {16'h0000, dt});
    wreg(pwm_edge_pkg::REG_CTRL, ctl);
    repeat (130) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    for (int b = 0; b < 8; b++)
    begin
      rise_at[b] = 16'hFFFF;
      fall_at[b] = 16'hFFFF;
    end
    repeat (140) @(posedge i_clk_sys);
  endtask

  task automatic t_reset();
    rreg(pwm_edge_pkg::REG_LIMIT, 32'h0000_00FF);
    rreg(pwm_edge_pkg::REG_CTRL, 32'h0000_0000);
    wreg(6'h3C, 32'h0000_1234);
    rreg(6'h3C, 32'h0000_0000);
    check({24'h000000, pwm}, 32'h0000_0000);
  endtask

  task automatic t_normal();
    wreg(pwm_edge_pkg::REG_LIMIT, 32'h0000_003F);
    wreg(pwm_edge_pkg::REG_ADAPT, 32'h0000_0001);
    wreg(pwm_edge_pkg::REG_PHASE, 32'h0000_001E);
    wreg(pwm_edge_pkg::REG_SAMPLE, 32'h0028_0000);
    wreg(pwm_edge_pkg::REG_BLANK_A, 32'h0009_0005);
    wreg(pwm_edge_pkg::REG_BLANK_B, 32'h0032_002D);
    setup(16'h4, 16'h14, 16'h17, 16'h32, 16'h2, 16'h7, 16'h3, 16'hA, 32'h10);
    check({16'h0000, per_len}, 32'h0000_0040);
    ck(7, 16'h0004, 16'h0010);
    ck(6, 16'h0013, 16'h0035);
    ck(6, 16'h0013, 16'h0035);
    ck(6, 16'h0013, 16'h0035);
    ck(5, 16'h000F, 16'hFFFF);
    ck(4, 16'h001E, 16'hFFFF);
    ck(2, 16'h0028, 16'hFFFF);
    ck(1, 16'h0005, 16'h0009);
    ck(0, 16'h002D, 16'h0032);
  endtask

  task automatic t_multi();
    setup(16'h4, 16'h14, 16'h1E, 16'h32, 16'h2, 16'h5, 16'h3, 16'hA, 32'h1D);
    ck(7, 16'h0004, 16'h0013);
    ck(6, 16'h001E, 16'h0030);
    ck(6, 16'h001E, 16'h0030);
    ck(5, 16'h000A, 16'hFFFF);
    ck(4, 16'h000A, 16'hFFFF);
    setup(16'h32, 16'h14, 16'h32, 16'h32, 16'h2, 16'h5, 16'h3, 16'hA, 32'h1D);
    ck(7, 16'h0032, 16'h003F);
    ck(6, 16'h0032, 16'h0004);
    ck(5, 16'h0038, 16'hFFFF);
  endtask

  task automatic t_reso();
    setup(16'h4, 16'h14, 16'h17, 16'h32, 16'h2, 16'h7, 16'h2, 16'h1E, 32'h12);
    ck(7, 16'h0004, 16'h001C);
    ck(6, 16'h0022, 16'h003A);
    ck(5, 16'h0023, 16'hFFFF);
    ck(1, 16'h0005, 16'h0009);
    wreg(pwm_edge_pkg::REG_CTRL, 32'h0000_0000);
    repeat (4) @(posedge i_clk_sys);
    check({24'h000000, pwm}, 32'h0000_0000);
    rreg(pwm_edge_pkg::REG_STATUS, 32'h0000_0000);
  endtask

  initial
  begin
    i_rst_n = 1'b0;
    adr     = 6'h00;
    rd      = 1'b0;
    wr      = 1'b0;
    wdat    = 32'h0000_0000;
    duty    = 16'h0000;
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    t_reset();
    t_normal();
    t_multi();
    t_reso();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    n_errors++;
    summarize();
  end
endmodule

// file: pwm_edge_gate.sv
// Set/reset gate for one output driven by compare matches
`timescale 1ns/1ps

module pwm_edge_gate #(
  parameter int W = 16
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  input  wire logic         i_run,
  input  wire logic [W-1:0] i_count,
  input  wire logic [W-1:0] i_rise,
  input  wire logic [W-1:0] i_fall,
  output logic              o_level
);

  wire hit_rise = (i_count == i_rise);
  wire hit_fall = (i_count == i_fall);

  // Fall wins when both targets coincide
  wire next_level = !i_run ? 1'b0 : hit_fall ? 1'b0 : hit_rise ? 1'b1 : o_level;

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_level <= 1'b0;
    else
      o_level <= next_level;
  end

endmodule

// file: pwm_edge_pkg.sv
// Package with constants and carrier types for the multimode PWM edge generator
package pwm_edge_pkg;

  localparam int CNT_W = 16;

  localparam logic [CNT_W-1:0] CNT_RESET  = 16'h0000;
  localparam logic [CNT_W-1:0] LIMIT_INIT = 16'h00FF;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_MULTI,
    MODE_RESONANT
  } pwm_mode_t;

  // Register offsets, byte addresses on a word-aligned Avalon-MM slave
  localparam logic [5:0] REG_CTRL      = 6'h00;
  localparam logic [5:0] REG_LIMIT     = 6'h04;
  localparam logic [5:0] REG_EVENT1    = 6'h08;
  localparam logic [5:0] REG_EVENT2    = 6'h0C;
  localparam logic [5:0] REG_EVENT3    = 6'h10;
  localparam logic [5:0] REG_EVENT4    = 6'h14;
  localparam logic [5:0] REG_ADJ_A     = 6'h18;
  localparam logic [5:0] REG_ADJ_B     = 6'h1C;
  localparam logic [5:0] REG_DTC       = 6'h20;
  localparam logic [5:0] REG_ADAPT     = 6'h24;
  localparam logic [5:0] REG_PHASE     = 6'h28;
  localparam logic [5:0] REG_SAMPLE    = 6'h2C;
  localparam logic [5:0] REG_BLANK_A   = 6'h30;
  localparam logic [5:0] REG_BLANK_B   = 6'h34;
  localparam logic [5:0] REG_STATUS    = 6'h38;

  // Control register fields
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_ADAPT_HALF = 2;
  localparam int CTRL_PHASE_DUTY = 3;
  localparam int CTRL_ENABLE     = 4;

  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic [CNT_W-1:0] duty;
    logic [CNT_W-1:0] period;
  } filter_in_t;

  typedef struct packed {
    logic pwm_a;
    logic pwm_b;
    logic adapt_trig;
    logic phase_trig;
    logic sample1;
    logic sample2;
    logic blank_a;
    logic blank_b;
  } pwm_out_t;

endpackage
